// ---- core/odls_delay_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Delay request from the sequencer to its timer.
// -----------------------------------------------------------------------------
interface odls_delay_if;
  import odls_pkg::*;
  // One-cycle pulse that loads a new wait.
  logic load;
  // Wait length in milliseconds.
  logic [DLY_W-1:0] ms;
  // One-cycle pulse when the wait has elapsed.
  logic done;
  modport seq (output load, output ms, input done);
  modport timer (input load, input ms, output done);
endinterface : odls_delay_if
`default_nettype wire

// ---- core/odls_delay_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Millisecond delay timer.
// -----------------------------------------------------------------------------
module odls_delay_timer
  import odls_pkg::*;
#(
  parameter int UNIT_CYCLES = MS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  odls_delay_if.timer dly
);

  localparam int CW = $clog2(UNIT_CYCLES + 1);

  // A unit shorter than one cycle cannot be counted.
  if (UNIT_CYCLES < 1)
  begin : g_chk
    $error("UNIT_CYCLES must be at least one");
  end

  logic [CW-1:0] tick; // Cycles elapsed in the current millisecond.
  logic [DLY_W-1:0] ms_left; // Whole milliseconds still to wait.
  logic active; // A wait is in progress.
  logic done_q; // Registered completion pulse.

  assign dly.done = done_q;

  // Count cycles into milliseconds; a zero wait finishes on the next edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick <= '0;
      ms_left <= '0;
      active <= 1'b0;
      done_q <= 1'b0;
    end
    else if (dly.load)
    begin
      tick <= '0;
      ms_left <= dly.ms;
      active <= (dly.ms != '0);
      done_q <= (dly.ms == '0);
    end
    else if (active && tick == CW'(UNIT_CYCLES - 1))
    begin
      // Millisecond boundary reached.
      tick <= '0;
      ms_left <= ms_left - 1'b1;
      active <= (ms_left != 1);
      done_q <= (ms_left == 1);
    end
    else
    begin
      tick <= active ? tick + 1'b1 : '0;
      done_q <= 1'b0;
    end
  end

endmodule : odls_delay_timer
`default_nettype wire

// ---- core/odls_loop_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module odls_loop_sequencer
  import odls_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int LOOP_W = CNT_W,
  parameter int UNIT_CYCLES = MS_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  // Entry table write port.
  input wire logic tbl_wr,
  input wire logic [ENTRY_W-1:0] tbl_idx,
  input wire logic tbl_abs,
  input wire logic [POS_W-1:0] tbl_pos,
  input wire logic [DLY_W-1:0] tbl_delay_ms,
  input wire logic [1:0] tbl_link,
  input wire logic [NEXT_W-1:0] tbl_next,
  input wire logic [LOOP_W-1:0] tbl_loop_count,
  input wire logic [OFS_W-1:0] tbl_loop_offset,
  input wire logic tbl_loop_end,
  // Host start controls.
  input wire logic [ENTRY_W-1:0] sel_entry,
  input wire logic start,
  input wire logic sequential_go_input,
  // Profile generator handshake.
  input wire logic prof_done,
  output logic ready,
  output logic seq_busy,
  output logic cmd_valid,
  output logic [ENTRY_W-1:0] cmd_index,
  output logic [POS_W-1:0] cmd_target,
  output logic cmd_abs,
  output logic cmd_blend,
  output logic [LOOP_W-1:0] loop_pass
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (DEPTH < 3 || DEPTH > 256 || LOOP_W < 1 || LOOP_W > 16)
  begin : g_chk
    $error("DEPTH must be 3 to 256 and LOOP_W 1 to 16");
  end

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta; // First stage; only the second stage reads it.
  logic rst_n; // Released copy used by the rest of the design.

  // Assert at once, release two edges later so no flop leaves reset on a
  // half-settled edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Entry table
  // ---------------------------------------------------------------------------
  logic e_abs [DEPTH]; // Absolute positioning entry.
  logic [POS_W-1:0] e_pos [DEPTH]; // Stored position.
  logic [DLY_W-1:0] e_dly [DEPTH]; // Drive-complete delay.
  logic [1:0] e_link [DEPTH]; // Chaining mode.
  logic [NEXT_W-1:0] e_next [DEPTH]; // Follow-on selector.
  logic [LOOP_W-1:0] e_cnt [DEPTH]; // Repeat count.
  logic [OFS_W-1:0] e_ofs [DEPTH]; // Per-loop offset, two's complement.
  logic e_lend [DEPTH]; // Loop-end flag.

  // Writes beyond the table are dropped; reset leaves every entry unchained.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        e_abs[i] <= 1'b0;
        e_pos[i] <= POS_RST;
        e_dly[i] <= '0;
        e_link[i] <= LINK_NONE;
        e_next[i] <= NEXT_STOP;
        e_cnt[i] <= '0;
        e_ofs[i] <= '0;
        e_lend[i] <= LEND_NONE;
      end
    end
    else if (tbl_wr && 32'(tbl_idx) < DEPTH)
    begin
      e_abs[tbl_idx] <= tbl_abs;
      e_pos[tbl_idx] <= tbl_pos;
      e_dly[tbl_idx] <= tbl_delay_ms;
      e_link[tbl_idx] <= tbl_link;
      e_next[tbl_idx] <= tbl_next;
      e_cnt[tbl_idx] <= tbl_loop_count;
      e_ofs[tbl_idx] <= tbl_loop_offset;
      e_lend[tbl_idx] <= tbl_loop_end;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  odls_state_t state; // Present state.
  odls_state_t next_state; // State for the next edge.
  logic [ENTRY_W-1:0] cur; // Entry being executed.
  logic loop_on; // A loop span is open.
  logic [ENTRY_W-1:0] loop_head; // Entry that opened the loop.
  logic [LOOP_W-1:0] loop_left; // Passes still to run, this one included.
  logic start_q; // Previous start level, for edge detection.
  logic go_q; // Previous sequential go level.
  logic start_edge; // Rising edge of start.
  logic go_edge; // Rising edge of sequential go.
  logic opens_loop; // Current entry opens a new loop.
  logic at_close; // Current entry closes an open loop.
  logic repeat_span; // Loop end reached with passes left.
  logic [ENTRY_W:0] succ; // Successor index, one bit wider.
  logic succ_stop; // No successor: the sequence ends.
  logic [POS_W-1:0] next_target; // Target for the entry being issued.
  odls_delay_if dly ();

  assign start_edge = start && !start_q;
  assign go_edge = sequential_go_input && !go_q;

  // Keep the host levels so only new presses count; a held input does not
  // start a second sequence.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= 1'b0;
      go_q <= 1'b0;
    end
    else
    begin
      start_q <= start;
      go_q <= sequential_go_input;
    end
  end

  // An entry with a nonzero count opens a loop unless it already heads
  // the open one; loops do not nest.
  assign opens_loop = (e_cnt[cur] != '0) && !(loop_on && cur == loop_head);
  assign at_close = loop_on && (e_lend[cur] == LEND_CLOSE);
  assign repeat_span = at_close && (loop_left > 1);

  // Target of the issued entry: pass k shifts an absolute target by k
  // offsets; a freshly opened loop is pass zero.
  always_comb
  begin
    logic [LOOP_W:0] k;
    logic [POS_W-1:0] ofs_ext;
    logic [POS_W-1:0] shift;
    k = opens_loop ? '0 : {1'b0, loop_pass};
    // Widen the offset before multiplying; a product kept at the offset's
    // own width would lose its top bits after a few passes.
    ofs_ext = {{(POS_W-OFS_W){e_ofs[cur][OFS_W-1]}}, e_ofs[cur]};
    shift = ofs_ext * POS_W'(k);
    if (e_abs[cur] && (loop_on || opens_loop))
    begin
      next_target = e_pos[cur] + shift;
    end
    else
    begin
      next_target = e_pos[cur];
    end
  end

  // Successor of the current entry once it completes.
  always_comb
  begin
    succ = {1'b0, cur};
    succ_stop = 1'b0;
    if (repeat_span)
    begin
      succ = {1'b0, loop_head};
    end
    else if (e_next[cur] == NEXT_STOP)
    begin
      succ_stop = 1'b1;
    end
    else if (e_next[cur] == NEXT_PLUS2)
    begin
      succ = {1'b0, cur} + 9'h002;
    end
    else if (e_next[cur] == NEXT_PLUS1)
    begin
      succ = {1'b0, cur} + 9'h001;
    end
    else if (e_next[cur][NEXT_W-1])
    begin
      // Other negative codes are not defined and end the sequence.
      succ_stop = 1'b1;
    end
    else
    begin
      succ = e_next[cur];
    end
    // Running off the end of a shorter table ends the sequence.
    if (32'(succ) >= DEPTH)
    begin
      succ_stop = 1'b1;
    end
  end

  // Next-state decision.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (start_edge && 32'(sel_entry) < DEPTH)
        begin
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (prof_done)
        begin
          if (e_link[cur] == LINK_NONE || succ_stop)
          begin
            next_state = ST_IDLE;
          end
          else if (e_link[cur] == LINK_MANUAL)
          begin
            next_state = ST_WAIT;
          end
          else if (e_link[cur] == LINK_AUTO)
          begin
            next_state = ST_DELAY;
          end
          else
          begin
            next_state = ST_ISSUE;
          end
        end
      end
      ST_DELAY:
      begin
        if (dly.done)
        begin
          next_state = ST_ISSUE;
        end
      end
      ST_WAIT:
      begin
        if (go_edge)
        begin
          next_state = ST_ISSUE;
        end
      end
    endcase
  end

  // State with the host status lines registered alongside it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      ready <= 1'b1;
      seq_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ready <= (next_state == ST_IDLE) || (next_state == ST_WAIT);
      seq_busy <= (next_state != ST_IDLE);
    end
  end

  // Entry pointer: loaded from the host, advanced on completion.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= IDX_RST;
    end
    else if (state == ST_IDLE && next_state == ST_ISSUE)
    begin
      cur <= sel_entry;
    end
    else if (state == ST_RUN && prof_done && !succ_stop)
    begin
      cur <= succ[ENTRY_W-1:0];
    end
  end

  // Loop bookkeeping; a new sequence always starts outside any loop.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_on <= 1'b0;
      loop_head <= IDX_RST;
      loop_left <= '0;
      loop_pass <= '0;
    end
    else if (state == ST_IDLE)
    begin
      loop_on <= 1'b0;
      loop_pass <= '0;
    end
    else if (state == ST_ISSUE && opens_loop)
    begin
      loop_on <= 1'b1;
      loop_head <= cur;
      loop_left <= e_cnt[cur];
      loop_pass <= '0;
    end
    else if (state == ST_RUN && prof_done && at_close)
    begin
      // A halt on an unchained loop end also leaves the loop.
      loop_on <= repeat_span;
      loop_left <= loop_left - 1'b1;
      loop_pass <= repeat_span ? loop_pass + 1'b1 : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Command to the profile generator
  // ---------------------------------------------------------------------------
  // One pulse per issued entry; the blend flag asks the generator to carry
  // the present speed into the next entry instead of stopping first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      cmd_index <= IDX_RST;
      cmd_target <= POS_RST;
      cmd_abs <= 1'b0;
      cmd_blend <= 1'b0;
    end
    else
    begin
      cmd_valid <= (state == ST_ISSUE);
      if (state == ST_ISSUE)
      begin
        cmd_index <= cur;
        cmd_target <= next_target;
        cmd_abs <= e_abs[cur];
        cmd_blend <= (e_link[cur] == LINK_CONT) && (e_next[cur] != NEXT_STOP);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Drive-complete delay
  // ---------------------------------------------------------------------------
  assign dly.load = (state == ST_RUN) && (next_state == ST_DELAY);
  assign dly.ms = e_dly[cur];

  odls_delay_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_delay (
    .clk(clk),
    .rst_n(rst_n),
    .dly(dly.timer)
  );

endmodule : odls_loop_sequencer
`default_nettype wire

// ---- core/odls_pkg.sv ----
// -----------------------------------------------------------------------------
// Shared constants for the operation data loop sequencer.
// -----------------------------------------------------------------------------
package odls_pkg;

  // Entry index width; indexes 0 to 255 can be named.
  localparam int ENTRY_W = 8;
  // Target coordinate width in steps.
  localparam int POS_W = 32;
  // Loop offset width; holds -4,194,304 to 4,194,303.
  localparam int OFS_W = 23;
  // Follow-on selector width; holds -256 to 255.
  localparam int NEXT_W = 9;
  // Drive-complete delay width, in milliseconds.
  localparam int DLY_W = 16;
  // Default repeat count width.
  localparam int CNT_W = 8;

  // Chaining mode codes.
  localparam logic [1:0] LINK_NONE = 2'h0;
  localparam logic [1:0] LINK_MANUAL = 2'h1;
  localparam logic [1:0] LINK_AUTO = 2'h2;
  localparam logic [1:0] LINK_CONT = 2'h3;

  // Follow-on selector codes: -256 stop, -2 plus two, -1 plus one.
  localparam logic [NEXT_W-1:0] NEXT_STOP = 9'h100;
  localparam logic [NEXT_W-1:0] NEXT_PLUS2 = 9'h1FE;
  localparam logic [NEXT_W-1:0] NEXT_PLUS1 = 9'h1FF;

  // Loop-end flag codes.
  localparam logic LEND_NONE = 1'h0;
  localparam logic LEND_CLOSE = 1'h1;

  // Reset value of index and coordinates.
  localparam logic [ENTRY_W-1:0] IDX_RST = 8'h00;
  localparam logic [POS_W-1:0] POS_RST = 32'h00000000;

  // Clock and delay unit; cycles per delay unit are derived.
  localparam int CLK_PERIOD_NS = 20;
  localparam int DELAY_UNIT_NS = 1000000;
  localparam int MS_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // One-hot sequencer states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ISSUE = 5'h02,
    ST_RUN = 5'h04,
    ST_DELAY = 5'h08,
    ST_WAIT = 5'h10
  } odls_state_t;

endpackage : odls_pkg

// ---- testbench/odls_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------
// Host and motion stand-in.
// ---------------------------------------
module odls_host_model
(
  input wire logic clk,
  input wire logic cmd_valid,
  input wire logic ready,
  input wire logic seq_busy,
  input wire logic [3:0] lat,
  output logic prof_done,
  output logic sequential_go_input
);
  // Cycles left before the move reports done.
  logic [3:0] run_left;
  // Cycles left before the go edge.
  logic [3:0] go_left;
  initial
  begin
    prof_done = 1'b0;
    sequential_go_input = 1'b0;
    run_left = 4'h0;
    go_left = 4'h0;
  end
  // A move always takes lat cycles, so done never precedes its command.
  always @(posedge clk)
  begin
    prof_done <= 1'b0;
    if (cmd_valid)
      run_left <= lat;
    else if (run_left != 4'h0)
    begin
      run_left <= run_left - 4'h1;
      prof_done <= (run_left == 4'h1);
    end
  end
  // Go rises only once waiting shows, and is held until ready falls.
  always @(posedge clk)
  begin
    if (!(ready && seq_busy))
    begin
      sequential_go_input <= 1'b0;
      go_left <= lat;
    end
    else if (go_left != 4'h0)
      go_left <= go_left - 4'h1;
    else
      sequential_go_input <= 1'b1;
  end
endmodule : odls_host_model
`default_nettype wire

// ---- testbench/odls_loop_sequencer_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module odls_loop_sequencer_bench;
  import odls_pkg::*;
  // Four cycles per millisecond keeps delays short.
  localparam int UC = 4;
  logic clk, arst_n, tbl_wr, tbl_abs, tbl_loop_end, start, sgo, prof_done;
  logic ready, seq_busy, cmd_valid, cmd_abs, cmd_blend;
  logic [7:0] tbl_idx, tbl_loop_count, sel_entry, cmd_index, loop_pass;
  logic [31:0] tbl_pos, cmd_target, p0, p1, p3, p5;
  logic [15:0] tbl_delay_ms;
  logic [1:0] tbl_link;
  logic [8:0] tbl_next;
  logic [22:0] tbl_loop_offset, o1, o3;
  logic [3:0] lat;
  logic [49:0] q[$];
  int err_count, checked, cyc, done_cyc;
  // ---------------------------------------
  // Design and host stand-in.
  // ---------------------------------------
  odls_loop_sequencer #(.UNIT_CYCLES(UC)) uut (.clk(clk), .arst_n(arst_n),
    .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_abs(tbl_abs), .tbl_pos(tbl_pos),
    .tbl_delay_ms(tbl_delay_ms), .tbl_link(tbl_link), .tbl_next(tbl_next),
    .tbl_loop_count(tbl_loop_count), .tbl_loop_offset(tbl_loop_offset),
    .tbl_loop_end(tbl_loop_end), .sel_entry(sel_entry), .start(start),
    .sequential_go_input(sgo), .prof_done(prof_done), .ready(ready),
    .seq_busy(seq_busy), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_target(cmd_target), .cmd_abs(cmd_abs), .cmd_blend(cmd_blend),
    .loop_pass(loop_pass));
  odls_host_model host (.clk(clk), .cmd_valid(cmd_valid), .ready(ready),
    .seq_busy(seq_busy), .lat(lat), .prof_done(prof_done), .sequential_go_input(sgo));
  // ---------------------------------------
  // Shared tasks.
  // ---------------------------------------
  task automatic chk(input string nm, input logic [49:0] seen, input logic [49:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // All fields of one entry go in with a single strobe.
  task automatic wr(input logic [7:0] i, input logic a, input logic [31:0] p,
    input logic [15:0] d, input logic [1:0] l, input logic [8:0] n,
    input logic [7:0] c, input logic [22:0] o, input logic e);
    @(posedge clk);
    #1;
    {tbl_idx, tbl_abs, tbl_pos, tbl_delay_ms, tbl_link} = {i, a, p, d, l};
    {tbl_next, tbl_loop_count, tbl_loop_offset, tbl_loop_end} = {n, c, o, e};
    tbl_wr = 1'b1;
    @(posedge clk);
    #1;
    tbl_wr = 1'b0;
  endtask : wr
  // Expected command: only absolute entries move by pass times offset.
  task automatic note(input logic [7:0] i, input logic a, input logic [31:0] p,
    input logic [22:0] o, input int k, input logic b);
    logic [31:0] t;
    t = p + (a ? k * {{9{o[22]}}, o} : 32'h0);
    q.push_back({i, t, a, b, 8'(k)});
  endtask : note
  // Start is a level; hold it until busy shows, then wait for the end.
  task automatic run(input logic [7:0] e, input int n);
    int w;
    @(posedge clk);
    #1;
    sel_entry = e;
    start = 1'b1;
    w = 0;
    do
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (seq_busy !== 1'b1 && w < 10);
    start = 1'b0;
    w = 0;
    do
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (seq_busy !== 1'b0 && w < 3000);
    chk("busy", {49'h0, seq_busy}, 50'h0);
    chk("ready", {49'h0, ready}, 50'h1);
    chk("pending", 50'(q.size()), 50'h0);
    $display("test %0d done", n);
  endtask : run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ---------------------------------------
  // Clock, monitor and watchdog.
  // ---------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Commands are one cycle wide, so they are sampled mid-cycle.
  always @(negedge clk)
  begin
    cyc++;
    if (prof_done === 1'b1)
      done_cyc = cyc;
    if (cmd_valid === 1'b1)
    begin
      if (cmd_index === 8'h15)
        chk("delay", 50'(cyc - done_cyc > 2 * UC && cyc - done_cyc <= 2 * UC + 8), 50'h1);
      if (q.size() == 0)
        chk("extra", 50'h1, 50'h0);
      else
        chk("command", {cmd_index, cmd_target, cmd_abs, cmd_blend, loop_pass}, q.pop_front());
    end
  end
  // Ten thousand cycles is far beyond the few hundred the tests need.
  initial
  begin
    #200000;
    err_count++;
    close_out;
  end
  // ---------------------------------------
  // Main sequence.
  // ---------------------------------------
  initial
  begin
    {arst_n, tbl_wr, tbl_abs, tbl_loop_end, start, tbl_idx, tbl_loop_count} = '0;
    {sel_entry, tbl_pos, tbl_delay_ms, tbl_link, tbl_next, tbl_loop_offset} = '0;
    lat = 4'h1;
    void'($urandom(49));
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    // Three passes, blended loop end, absolute and plus-two follow-ons.
    for (int r = 0; r < 2; r++)
    begin
      lat = 4'(1 + $urandom % 4);
      {p0, p1, p3, p5} = {$urandom, $urandom, $urandom, $urandom};
      {o1, o3} = {23'($urandom), 23'($urandom)};
      wr(8'h00, 1'b1, p0, 16'h0, LINK_AUTO, NEXT_PLUS1, 8'h03, 23'h400000, 1'b0);
      wr(8'h01, 1'b0, p1, 16'h0, LINK_CONT, 9'h003, 8'h00, o1, 1'b1);
      wr(8'h03, 1'b1, p3, 16'h0, LINK_AUTO, NEXT_PLUS2, 8'h00, o3, 1'b0);
      wr(8'h05, 1'b0, p5, 16'h0, LINK_NONE, NEXT_PLUS1, 8'h00, o3, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
        note(8'h00, 1'b1, p0, 23'h400000, k, 1'b0);
        note(8'h01, 1'b0, p1, o1, k, 1'b1);
      end
      note(8'h03, 1'b1, p3, o3, 0, 1'b0);
      note(8'h05, 1'b0, p5, o3, 0, 1'b0);
      run(8'h00, r);
    end
    // Manual head, then an unchained entry that cuts the loop short.
    wr(8'h0A, 1'b1, p0, 16'h0, LINK_MANUAL, NEXT_PLUS1, 8'h02, 23'h3FFFFF, 1'b0);
    wr(8'h0B, 1'b1, p1, 16'h0, LINK_NONE, NEXT_PLUS1, 8'h00, o1, 1'b0);
    wr(8'h0C, 1'b1, p3, 16'h0, LINK_AUTO, NEXT_STOP, 8'h00, o1, 1'b1);
    note(8'h0A, 1'b1, p0, 23'h0, 0, 1'b0);
    note(8'h0B, 1'b1, p1, 23'h0, 0, 1'b0);
    run(8'h0A, 2);
    // Single pass with a two millisecond delay before the follow-on.
    wr(8'h14, 1'b1, p0, 16'h0002, LINK_AUTO, 9'h015, 8'h01, o1, 1'b1);
    wr(8'h15, 1'b0, p1, 16'h0, LINK_CONT, NEXT_STOP, 8'h00, o1, 1'b0);
    note(8'h14, 1'b1, p0, o1, 0, 1'b0);
    note(8'h15, 1'b0, p1, o1, 0, 1'b0);
    run(8'h14, 3);
    close_out;
  end
endmodule : odls_loop_sequencer_bench
`default_nettype wire

// ---- testbench/odls_loop_sequencer_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------
// Port checks of the sequencer.
// ---------------------------------------
module odls_loop_sequencer_sva
  import odls_pkg::*;
#(
  parameter int LOOP_W = CNT_W
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic sequential_go_input,
  input wire logic prof_done,
  input wire logic ready,
  input wire logic seq_busy,
  input wire logic cmd_valid,
  input wire logic cmd_blend,
  input wire logic [LOOP_W-1:0] loop_pass
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Issue cycle, then the one-cycle command.
  sequence issue_s;
    !ready && seq_busy ##1 cmd_valid;
  endsequence
  chk_start_issue: assert property ($rose(start) && ready && !seq_busy |=> issue_s)
    else $error("start did not issue a command");
  chk_go_issue: assert property (ready && seq_busy && $rose(sequential_go_input) |=> issue_s)
    else $error("go did not issue the next command");
  chk_wait_hold: assert property (ready && seq_busy && !$rose(sequential_go_input)
    |=> ready && seq_busy)
    else $error("manual wait left without go");
  chk_blend_next: assert property (prof_done && cmd_blend && seq_busy && !ready
    |-> ##2 cmd_valid)
    else $error("continuous entry did not chain");
  chk_cmd_pulse: assert property (cmd_valid |-> seq_busy && !ready ##1 !cmd_valid)
    else $error("command pulse malformed");
  chk_pass_idle: assert property (!seq_busy |-> loop_pass == '0)
    else $error("pass count kept outside a sequence");
  chk_pass_step: assert property ($changed(loop_pass) && loop_pass != '0
    |-> loop_pass == $past(loop_pass) + 1'b1)
    else $error("pass count skipped");
  chk_end_ready: assert property ($fell(seq_busy) |-> ready)
    else $error("sequence ended without ready");
endmodule : odls_loop_sequencer_sva
bind odls_loop_sequencer odls_loop_sequencer_sva #(.LOOP_W(LOOP_W)) u_sva (
  .clk(clk), .arst_n(arst_n), .start(start), .sequential_go_input(sequential_go_input),
  .prof_done(prof_done), .ready(ready), .seq_busy(seq_busy), .cmd_valid(cmd_valid),
  .cmd_blend(cmd_blend), .loop_pass(loop_pass));
`default_nettype wire
